/* hdl/wdg_pkg.sv */
// package: register map, field positions, reset values and bus carrier
package wdg_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 16;
  localparam logic [15:0] OFF_IRQ_EN  = 16'hfff3;
  localparam logic [15:0] OFF_STANDBY = 16'hfff1;
  localparam logic [15:0] OFF_CTRL    = 16'hffb2;
  localparam logic [15:0] OFF_COUNTER = 16'hffb3;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_RTC_EN  = 7;
  localparam int BIT_WDOG_SB = 2;
  localparam int BIT_CMP_SB  = 1;
  localparam int BIT_GUARD6  = 7;
  localparam int BIT_CWE     = 6;
  localparam int BIT_GUARD4  = 5;
  localparam int BIT_CRWE    = 4;
  localparam int BIT_GUARD2  = 3;
  localparam int BIT_RUN     = 2;
  localparam int BIT_GUARD0  = 1;
  localparam int BIT_FLAG    = 0;

  // guard bits always read back as ones
  localparam logic [7:0] GUARD_READ = 8'haa;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_RUN     = 1'b1;
  localparam logic RST_CWE     = 1'b0;
  localparam logic RST_CRWE    = 1'b0;
  localparam logic RST_FLAG    = 1'b0;
  localparam logic RST_WDOG_SB = 1'b0;
  localparam logic RST_CMP_SB  = 1'b0;
  localparam logic RST_RTC_EN  = 1'b0;

  // ---------------------------------------------------------------
  // register port carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wrData;
    logic              wrStrobe;
    logic              rdStrobe;
  } wdg_bus_s;

endpackage

/* hdl/wdg_guard.sv */
// watchdog control: guarded control/status register, counter, standby
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps

module wdg_guard
  import wdg_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             clkEn,
  input  wire wdg_bus_s         bus,
  output logic      [7:0]       rdData,
  input  wire logic             rtcIrqReq,
  output logic                  rtcIrqOut,
  output logic                  wdogStandby,
  output logic                  cmpStandby,
  output logic                  wdogReset
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  typedef struct packed {
    logic             counterWriteEnable;
    logic             ctrlWriteEnable;
    logic             counterRunning;
    logic             overflowResetFlag;
    logic             wdogStandbyReqN;
    logic             cmpStandbyReqN;
    logic             rtcIrqEnable;
    logic [CNT_W-1:0] wdogCounter;
    logic [7:0]       rdData;
    logic             rtcIrqOut;
    logic             wdogStandby;
    logic             cmpStandby;
    logic             wdogReset;
  } wdg_state_s;

  wdg_state_s state_reg;
  wdg_state_s state_next;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  logic             wrCtrl;
  logic             wrCount;
  logic             overflow;
  logic [7:0]       ctrlRead;
  logic [CNT_W-1:0] wrCountData;

  assign wrCtrl   = bus.wrStrobe && hit(bus.addr, OFF_CTRL);
  assign wrCount  = bus.wrStrobe && hit(bus.addr, OFF_COUNTER);
  assign overflow = state_reg.counterRunning &&
                    (state_reg.wdogCounter == CNT_MAX);
  assign wrCountData = CNT_W'(bus.wrData);

  // guard positions read as one, nothing is stored for them
  assign ctrlRead = GUARD_READ |
                    {1'b0, state_reg.counterWriteEnable,
                     1'b0, state_reg.ctrlWriteEnable,
                     1'b0, state_reg.counterRunning,
                     1'b0, state_reg.overflowResetFlag};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // guarded fields: each target moves only when its guard is 0
    if (wrCtrl) begin
      if (!bus.wrData[BIT_GUARD6]) begin
        state_next.counterWriteEnable = bus.wrData[BIT_CWE];
      end
      if (!bus.wrData[BIT_GUARD4]) begin
        state_next.ctrlWriteEnable = bus.wrData[BIT_CRWE];
      end
      // the enable in force before this write decides
      if (state_reg.ctrlWriteEnable) begin
        if (!bus.wrData[BIT_GUARD2]) begin
          state_next.counterRunning = bus.wrData[BIT_RUN];
        end
        if (!bus.wrData[BIT_GUARD0] && !bus.wrData[BIT_FLAG]) begin
          state_next.overflowResetFlag = 1'b0;
        end
      end
    end

    if (bus.wrStrobe && hit(bus.addr, OFF_STANDBY)) begin
      state_next.wdogStandbyReqN = bus.wrData[BIT_WDOG_SB];
      state_next.cmpStandbyReqN  = bus.wrData[BIT_CMP_SB];
    end
    if (bus.wrStrobe && hit(bus.addr, OFF_IRQ_EN)) begin
      state_next.rtcIrqEnable = bus.wrData[BIT_RTC_EN];
    end

    // counter: software write wins over the count step
    if (wrCount && state_reg.counterWriteEnable) begin
      state_next.wdogCounter = wrCountData;
    end else if (state_reg.counterRunning) begin
      state_next.wdogCounter = state_reg.wdogCounter + 1'b1;
    end

    // overflow: internal reset restarts the timer but keeps the flag;
    // the set beats a clear written in the same cycle
    state_next.wdogReset = overflow;
    if (overflow) begin
      state_next.overflowResetFlag  = 1'b1;
      state_next.counterRunning     = RST_RUN;
      state_next.counterWriteEnable = RST_CWE;
      state_next.ctrlWriteEnable    = RST_CRWE;
    end

    // read data stands only in the cycle after the strobe
    state_next.rdData = 8'h00;
    if (bus.rdStrobe) begin
      if (hit(bus.addr, OFF_CTRL)) begin
        state_next.rdData = ctrlRead;
      end else if (hit(bus.addr, OFF_COUNTER)) begin
        state_next.rdData = 8'(state_reg.wdogCounter);
      end else if (hit(bus.addr, OFF_STANDBY)) begin
        state_next.rdData = 8'h00;
        state_next.rdData[BIT_WDOG_SB] = state_reg.wdogStandbyReqN;
        state_next.rdData[BIT_CMP_SB]  = state_reg.cmpStandbyReqN;
      end else if (hit(bus.addr, OFF_IRQ_EN)) begin
        state_next.rdData[BIT_RTC_EN] = state_reg.rtcIrqEnable;
      end
    end

    state_next.rtcIrqOut = rtcIrqReq && state_reg.rtcIrqEnable;
    // a running counter holds the watchdog out of standby
    state_next.wdogStandby = !state_reg.wdogStandbyReqN &&
                             !state_reg.counterRunning;
    state_next.cmpStandby  = !state_reg.cmpStandbyReqN;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg                    <= '0;
      state_reg.counterWriteEnable <= RST_CWE;
      state_reg.ctrlWriteEnable    <= RST_CRWE;
      state_reg.counterRunning     <= RST_RUN;
      state_reg.overflowResetFlag  <= RST_FLAG;
      state_reg.wdogStandbyReqN    <= RST_WDOG_SB;
      state_reg.cmpStandbyReqN     <= RST_CMP_SB;
      state_reg.rtcIrqEnable       <= RST_RTC_EN;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign rdData      = state_reg.rdData;
  assign rtcIrqOut   = state_reg.rtcIrqOut;
  assign wdogStandby = state_reg.wdogStandby;
  assign cmpStandby  = state_reg.cmpStandby;
  assign wdogReset   = state_reg.wdogReset;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_ctrlWrite;
    clkEn && wrCtrl;
  endsequence

  sequence s_guardedWrite;
    clkEn && wrCtrl && state_reg.ctrlWriteEnable;
  endsequence

  sequence s_standbyWrite;
    clkEn && bus.wrStrobe && hit(bus.addr, OFF_STANDBY);
  endsequence

  property p_cweGuarded;
    @(posedge clk_sys) disable iff (reset)
    s_ctrlWrite ##0 (bus.wrData[BIT_GUARD6] && !overflow)
      |=> $stable(state_reg.counterWriteEnable);
  endproperty
  a_cweGuarded: assert property (p_cweGuarded)
    else $error("counter write enable moved without guard cleared");

  property p_cweLoad;
    @(posedge clk_sys) disable iff (reset)
    s_ctrlWrite ##0 (!bus.wrData[BIT_GUARD6] && !overflow)
      |=> state_reg.counterWriteEnable == $past(bus.wrData[BIT_CWE]);
  endproperty
  a_cweLoad: assert property (p_cweLoad)
    else $error("counter write enable not loaded");

  property p_crweGuarded;
    @(posedge clk_sys) disable iff (reset)
    s_ctrlWrite ##0 (bus.wrData[BIT_GUARD4] && !overflow)
      |=> $stable(state_reg.ctrlWriteEnable);
  endproperty
  a_crweGuarded: assert property (p_crweGuarded)
    else $error("register write enable moved without guard cleared");

  property p_crweLoad;
    @(posedge clk_sys) disable iff (reset)
    s_ctrlWrite ##0 (!bus.wrData[BIT_GUARD4] && !overflow)
      |=> state_reg.ctrlWriteEnable == $past(bus.wrData[BIT_CRWE]);
  endproperty
  a_crweLoad: assert property (p_crweLoad)
    else $error("register write enable not loaded");

  property p_runLocked;
    @(posedge clk_sys) disable iff (reset)
    s_ctrlWrite ##0 !state_reg.ctrlWriteEnable
      |=> $stable(state_reg.counterRunning);
  endproperty
  a_runLocked: assert property (p_runLocked)
    else $error("running bit changed while register writes locked");

  property p_runWrite;
    @(posedge clk_sys) disable iff (reset)
    s_guardedWrite ##0 (!bus.wrData[BIT_GUARD2] && !overflow)
      |=> state_reg.counterRunning == $past(bus.wrData[BIT_RUN]);
  endproperty
  a_runWrite: assert property (p_runWrite)
    else $error("running bit did not follow guarded write");

  property p_counterLocked;
    @(posedge clk_sys) disable iff (reset)
    clkEn && wrCount && !state_reg.counterWriteEnable &&
      !state_reg.counterRunning |=> $stable(state_reg.wdogCounter);
  endproperty
  a_counterLocked: assert property (p_counterLocked)
    else $error("counter accepted a write while locked");

  property p_counterLoad;
    @(posedge clk_sys) disable iff (reset)
    clkEn && wrCount && state_reg.counterWriteEnable
      |=> state_reg.wdogCounter == $past(wrCountData);
  endproperty
  a_counterLoad: assert property (p_counterLoad)
    else $error("counter ignored an enabled write");

  // both steps need the running bit and no load, else a stop or a
  // software write in the middle legally breaks the two-step sum;
  // the sampled reset keeps the release edge out of the window
  property p_counterCount;
    @(posedge clk_sys) disable iff (reset)
    !reset && clkEn && !wrCount && state_reg.counterRunning
      ##1 (clkEn && !wrCount && state_reg.counterRunning)
      |=> state_reg.wdogCounter == $past(state_reg.wdogCounter, 2) + 2'd2;
  endproperty
  a_counterCount: assert property (p_counterCount)
    else $error("running counter did not step by one per cycle");

  property p_overflow;
    @(posedge clk_sys) disable iff (reset)
    clkEn && overflow |=> wdogReset && state_reg.overflowResetFlag
      && state_reg.counterRunning;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow did not raise reset and flag");

  property p_flagClear;
    @(posedge clk_sys) disable iff (reset)
    s_guardedWrite ##0 (bus.wrData[1:0] == 2'b00 && !overflow)
      |=> !state_reg.overflowResetFlag;
  endproperty
  a_flagClear: assert property (p_flagClear)
    else $error("overflow flag not cleared by guarded write");

  property p_standbyHeld;
    @(posedge clk_sys) disable iff (reset)
    clkEn && state_reg.counterRunning |=> !wdogStandby;
  endproperty
  a_standbyHeld: assert property (p_standbyHeld)
    else $error("watchdog in standby while counter runs");

  property p_standbyEnter;
    @(posedge clk_sys) disable iff (reset)
    clkEn && !state_reg.wdogStandbyReqN && !state_reg.counterRunning
      |=> wdogStandby;
  endproperty
  a_standbyEnter: assert property (p_standbyEnter)
    else $error("watchdog failed to enter standby");

  property p_standbyOnStop;
    @(posedge clk_sys) disable iff (reset)
    clkEn && !state_reg.wdogStandbyReqN &&
      $fell(state_reg.counterRunning) |=> wdogStandby;
  endproperty
  a_standbyOnStop: assert property (p_standbyOnStop)
    else $error("pending standby did not follow counter stop");

  property p_standbyStore;
    @(posedge clk_sys) disable iff (reset)
    s_standbyWrite
      |=> state_reg.wdogStandbyReqN == $past(bus.wrData[BIT_WDOG_SB])
      && state_reg.cmpStandbyReqN == $past(bus.wrData[BIT_CMP_SB]);
  endproperty
  a_standbyStore: assert property (p_standbyStore)
    else $error("standby request bits not stored as written");

  // the release edge still ran the reset branch, so it is left out
  property p_cmpStandby;
    @(posedge clk_sys) disable iff (reset)
    !reset && clkEn |=> cmpStandby == !$past(state_reg.cmpStandbyReqN);
  endproperty
  a_cmpStandby: assert property (p_cmpStandby)
    else $error("comparator standby does not follow request");

  property p_reservedRead;
    @(posedge clk_sys) disable iff (reset)
    clkEn && bus.rdStrobe && hit(bus.addr, OFF_STANDBY) |=> !rdData[0];
  endproperty
  a_reservedRead: assert property (p_reservedRead)
    else $error("reserved standby bit read as one");

  property p_guardRead;
    @(posedge clk_sys) disable iff (reset)
    clkEn && bus.rdStrobe && hit(bus.addr, OFF_CTRL)
      |=> (rdData & GUARD_READ) == GUARD_READ;
  endproperty
  a_guardRead: assert property (p_guardRead)
    else $error("guard bits did not read as one");

  property p_rtcGate;
    @(posedge clk_sys) disable iff (reset)
    clkEn && !state_reg.rtcIrqEnable |=> !rtcIrqOut;
  endproperty
  a_rtcGate: assert property (p_rtcGate)
    else $error("rtc request passed while disabled");

  property p_rtcPass;
    @(posedge clk_sys) disable iff (reset)
    clkEn && rtcIrqReq && state_reg.rtcIrqEnable |=> rtcIrqOut;
  endproperty
  a_rtcPass: assert property (p_rtcPass)
    else $error("rtc request blocked while enabled");

endmodule // wdg_guard

/* verification/wdg_guard_tb_top.sv */
// testbench: guarded watchdog control register, counter, standby, irq gate
`timescale 1ns/1ps

`define CHK(got, exp) begin \
  checksDone++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); \
  end \
end

module wdg_guard_tb_top;
  import wdg_pkg::*;

  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  logic       clk_sys;
  logic       reset;
  logic       clkEn;
  wdg_bus_s   bus;
  logic [7:0] rdData;
  logic       rtcIrqReq;
  logic       rtcIrqOut;
  logic       wdogStandby;
  logic       cmpStandby;
  logic       wdogReset;
  int         failures;
  int         checksDone;

  wdg_guard uut (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .clkEn       (clkEn),
    .bus         (bus),
    .rdData      (rdData),
    .rtcIrqReq   (rtcIrqReq),
    .rtcIrqOut   (rtcIrqOut),
    .wdogStandby (wdogStandby),
    .cmpStandby  (cmpStandby),
    .wdogReset   (wdogReset)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
    @(posedge clk_sys);
    bus.wrStrobe <= 1'b0;
  endtask

  // data is looked at in the one cycle it stands, away from the edge
  task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus <= '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
    @(posedge clk_sys);
    bus.rdStrobe <= 1'b0;
    @(negedge clk_sys);
    `CHK(rdData, e)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic doReset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
  endtask

  // bounded wait for the one-cycle internal reset pulse
  task automatic waitPulse(input int maxCycles);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (wdogReset !== 1'b1 && n < maxCycles) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(wdogReset, 1'b1)
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic resetAndStandby();
    rdChk(OFF_CTRL, 8'hae);
    rdChk(OFF_IRQ_EN, 8'h00);
    rdChk(16'h0000, 8'h00);
    `CHK(cmpStandby, 1'b1)
    `CHK(wdogStandby, 1'b0)
    wr(OFF_STANDBY, 8'h03);
    rdChk(OFF_STANDBY, 8'h02);
    idle(2);
    `CHK(cmpStandby, 1'b0)
    `CHK(wdogStandby, 1'b0)
  endtask

  task automatic guardsAndStop();
    wr(OFF_CTRL, 8'hc0);
    rdChk(OFF_CTRL, 8'hae);
    wr(OFF_CTRL, 8'hf2);
    rdChk(OFF_CTRL, 8'hae);
    wr(OFF_CTRL, 8'hdf);
    rdChk(OFF_CTRL, 8'hbe);
    wr(OFF_CTRL, 8'hfa);
    rdChk(OFF_CTRL, 8'hbe);
    wr(OFF_CTRL, 8'hf2);
    rdChk(OFF_CTRL, 8'hba);
    idle(2);
    `CHK(wdogStandby, 1'b1)
  endtask

  task automatic counterAndOverflow();
    wr(OFF_CTRL, 8'h7a);
    rdChk(OFF_CTRL, 8'hfa);
    wr(OFF_COUNTER, 8'h20);
    idle(5);
    rdChk(OFF_COUNTER, 8'h20);
    wr(OFF_CTRL, 8'h3a);
    wr(OFF_COUNTER, 8'h30);
    rdChk(OFF_COUNTER, 8'h20);
    wr(OFF_CTRL, 8'h7a);
    wr(OFF_COUNTER, 8'hfc);
    wr(OFF_CTRL, 8'hf6);
    waitPulse(10);
    rdChk(OFF_CTRL, 8'haf);
  endtask

  task automatic flagClear();
    wr(OFF_CTRL, 8'hdf);
    wr(OFF_CTRL, 8'hfe);
    rdChk(OFF_CTRL, 8'hbf);
    wr(OFF_CTRL, 8'hfc);
    rdChk(OFF_CTRL, 8'hbe);
    waitPulse(300);
    rdChk(OFF_CTRL, 8'haf);
    doReset();
    rdChk(OFF_CTRL, 8'hae);
  endtask

  task automatic irqGate();
    @(posedge clk_sys);
    rtcIrqReq <= 1'b1;
    idle(3);
    `CHK(rtcIrqOut, 1'b0)
    @(posedge clk_sys);
    clkEn <= 1'b0;
    wr(OFF_IRQ_EN, 8'hff);
    clkEn <= 1'b1;
    rdChk(OFF_IRQ_EN, 8'h00);
    wr(OFF_IRQ_EN, 8'hff);
    rdChk(OFF_IRQ_EN, 8'h80);
    idle(1);
    `CHK(rtcIrqOut, 1'b1)
    @(posedge clk_sys);
    rtcIrqReq <= 1'b0;
    idle(3);
    `CHK(rtcIrqOut, 1'b0)
  endtask

  // ---------------------------------------------------------------
  // verdict and sequencing
  // ---------------------------------------------------------------
  task automatic final_report();
    if (failures == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // the whole run is about 350 cycles; this leaves ample margin
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    final_report();
  end

  initial begin
    reset      = 1'b1;
    clkEn      = 1'b1;
    bus        = '0;
    rtcIrqReq  = 1'b0;
    failures   = 0;
    checksDone = 0;
    doReset();
    resetAndStandby();
    guardsAndStop();
    counterAndOverflow();
    flagClear();
    irqGate();
    final_report();
  end

endmodule // wdg_guard_tb_top
